// file: tb/rag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory array behind the guard
// ==========================================================
module rag_mem_model
    import rag_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Request as the memory sees it
    input wire rag_req_t req,
    // Write passed on by the guard
    input wire logic wrEn,
    input wire logic [BLK_W-1:0] wrBlock,
    input wire logic [DATA_W-1:0] wrData,
    // Read data, combinational
    output logic [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [NUM_BLOCKS];
    // Distinct word per block so a wrong block index shows up
    initial begin
        for (int i = 0; i < NUM_BLOCKS; i++) mem[i] = 32'h5A5A0000 + 32'(i);
    end
    // Idle bus shows inverted data, never a stale word that could match
    assign rdData = req.valid ? mem[req.block] : ~mem[req.block];
    // Only writes that the guard issues reach the array
    always @(posedge ref_clk) begin
        if (wrEn) mem[wrBlock] <= wrData;
    end
endmodule : rag_mem_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rag_pkg::*;
;
    // ==========================================================
    // Signals
    // ==========================================================
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    rag_req_t reqIn = '0;
    rag_cfg_t cfgIn = '0;
    logic ctlWrEn = 1'b0;
    logic [CTL_SEL_W-1:0] ctlWrSel = '0;
    logic [CTL_W-1:0] ctlWrData = '0;
    logic [NUM_CTL-1:0] lockSet = '0;
    logic [DATA_W-1:0] memRdData, rdDataOut, memWrData;
    rag_resp_t respOut;
    logic memWrEn, ctlWrBlocked;
    logic [BLK_W-1:0] memWrBlock;
    logic [NUM_CTL-1:0][CTL_W-1:0] ctlRegs;
    logic [NUM_CTL-1:0] lockBits;
    logic [DATA_W-1:0] memExp [NUM_BLOCKS];
    logic [CTL_W-1:0] ctlExp [NUM_CTL];
    logic [NUM_CTL-1:0] lockExp = '0;
    int errCount = 0;
    int nTests = 0;
    // Clock, 8 ns period
    always #4 ref_clk = ~ref_clk;
    rag_guard dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reqIn(reqIn),
        .memRdData(memRdData), .cfgIn(cfgIn), .ctlWrEn(ctlWrEn), .ctlWrSel(ctlWrSel),
        .ctlWrData(ctlWrData), .lockSet(lockSet), .respOut(respOut), .rdDataOut(rdDataOut),
        .memWrEn(memWrEn), .memWrBlock(memWrBlock), .memWrData(memWrData),
        .ctlRegs(ctlRegs), .lockBits(lockBits), .ctlWrBlocked(ctlWrBlocked));
    rag_mem_model mem (.ref_clk(ref_clk), .req(reqIn), .wrEn(memWrEn),
        .wrBlock(memWrBlock), .wrData(memWrData), .rdData(memRdData));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finalReport
    // Reset is raised on an edge; at power-up eight edges see it high
    task automatic doReset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (7) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        lockExp = '0;
        for (int i = 0; i < NUM_CTL; i++) ctlExp[i] = CTL_RESET;
        chk("lockBits", '0, lockBits);
        for (int i = 0; i < NUM_CTL; i++) chk("ctlRegs", CTL_RESET, ctlRegs[i]);
        chk("respValid", 0, respOut.valid);
    endtask : doReset
    // One request, answer judged one cycle later
    task automatic acc(input logic [1:0] ini, input logic [2:0] blk, input rag_kind_t k,
                       input logic [31:0] wd, input logic g);
        @(posedge ref_clk);
        reqIn <= '{1'b1, ini, blk, k, wd};
        @(posedge ref_clk);
        reqIn.valid <= 1'b0;
        #1;
        chk("valid", 1, respOut.valid);
        chk("grant", g, respOut.grant);
        chk("respInit", ini, respOut.init);
        chk("respBlock", blk, respOut.block);
        chk("respKind", k, respOut.kind);
        chk("rdData", (g && k != ACC_WRITE) ? memExp[blk] : '0, rdDataOut);
        chk("memWrEn", g && k == ACC_WRITE, memWrEn);
        if (g && k == ACC_WRITE) begin
            chk("memWrBlock", blk, memWrBlock);
            chk("memWrData", wd, memWrData);
            memExp[blk] = wd;
        end
    endtask : acc
    task automatic cfg(input logic [2:0] blk, input logic [5:0] p);
        @(posedge ref_clk);
        cfgIn <= '{1'b1, blk, p};
        @(posedge ref_clk);
        cfgIn.wrEn <= 1'b0;
    endtask : cfg
    // Fetch and write from every initiator, then read back the block
    task automatic sweep(input logic [2:0] blk, input logic [5:0] p, input logic low);
        cfg(blk, p);
        for (int i = 0; i < NUM_INIT; i++) begin
            acc(2'(i), blk, ACC_FETCH, '0, low | p[2*i]);
            acc(2'(i), blk, ACC_WRITE, 32'hC0DE0000 + 32'(16 * i + blk), low | p[2*i+1]);
        end
        acc(INIT_DMA, blk, ACC_READ, '0, 1'b1);
    endtask : sweep
    task automatic ctlw(input int s, input logic [15:0] d);
        @(posedge ref_clk);
        ctlWrEn <= 1'b1;
        ctlWrSel <= 2'(s);
        ctlWrData <= d;
        @(posedge ref_clk);
        ctlWrEn <= 1'b0;
        #1;
        if (!lockExp[s]) ctlExp[s] = d;
        chk("ctlBlocked", lockExp[s], ctlWrBlocked);
        chk("ctlReg", ctlExp[s], ctlRegs[s]);
    endtask : ctlw
    task automatic lock(input int s);
        @(posedge ref_clk);
        lockSet <= 4'h1 << s;
        @(posedge ref_clk);
        lockSet <= '0;
        #1;
        lockExp[s] = 1'b1;
        chk("lockBits", lockExp, lockBits);
    endtask : lock
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic tReads();
        cfg(3'h5, 6'h00);
        for (int i = 0; i < NUM_INIT; i++) acc(2'(i), 3'h5, ACC_READ, '0, 1'b1);
        acc(2'h3, 3'h5, ACC_READ, '0, 1'b0);
        $display("test reads done");
    endtask : tReads
    task automatic tFilter();
        sweep(3'h4, 6'h3F, 1'b0);
        sweep(3'h3, 6'h26, 1'b0);
        sweep(3'h3, 6'h19, 1'b0);
        sweep(3'h7, 6'h3B, 1'b0);
        sweep(3'h7, 6'h00, 1'b0);
        sweep(3'h0, 6'h00, 1'b1);
        sweep(3'h1, 6'h00, 1'b1);
        $display("test filter done");
    endtask : tFilter
    task automatic tRuntime();
        cfg(3'h6, 6'h00);
        acc(INIT_CPU, 3'h6, ACC_WRITE, 32'h11112222, 1'b0);
        cfg(3'h6, 6'h3F);
        acc(INIT_CPU, 3'h6, ACC_WRITE, 32'h33334444, 1'b1);
        // A request in the same cycle as a config write still sees the old row
        @(posedge ref_clk);
        cfgIn <= '{1'b1, 3'h6, 6'h00};
        reqIn <= '{1'b1, INIT_CPU, 3'h6, ACC_WRITE, 32'h55556666};
        @(posedge ref_clk);
        cfgIn.wrEn <= 1'b0;
        reqIn.valid <= 1'b0;
        #1;
        chk("sameCycleGrant", 1, respOut.grant);
        memExp[6] = 32'h55556666;
        acc(INIT_CPU, 3'h6, ACC_WRITE, 32'h77778888, 1'b0);
        acc(INIT_CPU, 3'h6, ACC_READ, '0, 1'b1);
        $display("test runtime done");
    endtask : tRuntime
    task automatic tLock();
        ctlw(2, 16'h1234);
        lock(2);
        ctlw(2, 16'hBEEF);
        ctlw(1, 16'hA5A5);
        lock(0);
        ctlw(0, 16'h5A5A);
        doReset();
        ctlw(2, 16'h0F0F);
        $display("test lock done");
    endtask : tLock
    // Enable low: a pending write and a control write must leave no trace
    task automatic tFreeze();
        @(posedge ref_clk);
        ce <= 1'b0;
        reqIn <= '{1'b1, INIT_CPU, 3'h4, ACC_WRITE, 32'hDEAD0001};
        ctlWrEn <= 1'b1;
        ctlWrSel <= 2'h3;
        ctlWrData <= 16'h7777;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("frozenValid", 0, respOut.valid);
        chk("frozenWrEn", 0, memWrEn);
        chk("frozenCtl", ctlExp[3], ctlRegs[3]);
        @(posedge ref_clk);
        ce <= 1'b1;
        reqIn.valid <= 1'b0;
        ctlWrEn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("frozenCtl", ctlExp[3], ctlRegs[3]);
        acc(INIT_CPU, 3'h4, ACC_READ, '0, 1'b1);
        $display("test freeze done");
    endtask : tFreeze
    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    initial begin
        for (int i = 0; i < NUM_BLOCKS; i++) memExp[i] = 32'h5A5A0000 + 32'(i);
        doReset();
        tReads();
        tFilter();
        tRuntime();
        tLock();
        tFreeze();
        finalReport();
    end
    initial begin
        #200000;
        errCount++;
        finalReport();
    end
endmodule : testbench
`default_nettype wire

// file: verilog/rag_guard.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Per block and per initiator, fetch and write can be granted or denied.
// - Reads are never filtered for any initiator with a path.
// - The two low CPU blocks are never filtered.
// - The external memory block is filtered the same as internal blocks.
// - Permissions stay writable at run time and act on the next request.
// - Once a lock bit is set, writes to its control register are ignored.
// - Software cannot clear a lock bit; only reset unlocks.
module rag_guard
    import rag_pkg::*;
#(
    parameter int NBLK = NUM_BLOCKS,
    parameter int NLOW = NUM_LOW_BLOCKS,
    parameter int NCTL = NUM_CTL
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Access request from the bus fabric and memory read data
    input wire rag_req_t reqIn,
    input wire logic [DATA_W-1:0] memRdData,
    // Permission configuration port
    input wire rag_cfg_t cfgIn,
    // Critical control registers and their locks
    input wire logic ctlWrEn,
    input wire logic [CTL_SEL_W-1:0] ctlWrSel,
    input wire logic [CTL_W-1:0] ctlWrData,
    input wire logic [NCTL-1:0] lockSet,
    // Response to the initiator
    output rag_resp_t respOut,
    output logic [DATA_W-1:0] rdDataOut,
    // Write issued to the memory block
    output logic memWrEn,
    output logic [BLK_W-1:0] memWrBlock,
    output logic [DATA_W-1:0] memWrData,
    // Lockable control state
    output logic [NCTL-1:0][CTL_W-1:0] ctlRegs,
    output logic [NCTL-1:0] lockBits,
    output logic ctlWrBlocked
);
    typedef struct packed {
        logic [NBLK-1:0][PERM_ROW_W-1:0] perm;
        rag_resp_t resp;
        logic [DATA_W-1:0] rdData;
        logic wrEn;
        logic [BLK_W-1:0] wrBlock;
        logic [DATA_W-1:0] wrData;
    } rag_state_t;

    rag_state_t st_q;
    rag_state_t st_d;
    logic legal;
    logic filtered;
    logic allow;
    logic [PERM_W-1:0] permPair;

    // ==========================================================
    // Access decision
    // ==========================================================
    // Each permission row holds one fetch/write pair per initiator:
    // bit 2i+0 allows fetch and bit 2i+1 allows write for initiator i.
    // The decision is purely combinational on the request, so the answer
    // costs exactly one register stage.
    // Unknown initiator or block has no path at all, so even reads fail
    always_comb begin
        legal = (reqIn.init < NUM_INIT[1:0]) && (32'(reqIn.block) < NBLK);
        filtered = 32'(reqIn.block) >= NLOW;
        permPair = legal ? st_q.perm[reqIn.block][reqIn.init * PERM_W +: PERM_W] : '0;
        // external block shares the table; it is just the top index
        unique case (reqIn.kind)
            ACC_READ: allow = legal;
            ACC_FETCH: allow = legal && (!filtered || permPair[PERM_FETCH_BIT]);
            ACC_WRITE: allow = legal && (!filtered || permPair[PERM_WRITE_BIT]);
            default: allow = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    // A config write and a request in one cycle: the request is judged on
    // the old row and the new row acts from the next edge on. This keeps
    // the decision path free of a bypass mux.
    always_comb begin
        st_d = st_q;
        if (cfgIn.wrEn && 32'(cfgIn.block) < NBLK) begin
            st_d.perm[cfgIn.block] = cfgIn.perm;
        end
        st_d.resp.valid = reqIn.valid;
        st_d.resp.grant = reqIn.valid && allow;
        st_d.resp.init = reqIn.init;
        st_d.resp.block = reqIn.block;
        st_d.resp.kind = reqIn.kind;
        // denied access has no effect
        // Data is zeroed rather than held so a refused fetch leaks nothing
        st_d.rdData = (reqIn.valid && allow && reqIn.kind != ACC_WRITE) ? memRdData : '0;
        st_d.wrEn = reqIn.valid && allow && reqIn.kind == ACC_WRITE;
        st_d.wrBlock = reqIn.block;
        st_d.wrData = reqIn.wrData;
    end

    // Single register stage; ce low freezes everything
    // Reset opens every permission so boot code can run from any block;
    // software narrows the table afterwards.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q.perm <= {NBLK{PERM_RESET}};
            st_q.resp <= '0;
            st_q.rdData <= '0;
            st_q.wrEn <= 1'b0;
            st_q.wrBlock <= '0;
            st_q.wrData <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // All outputs leave straight from the state register
    assign respOut = st_q.resp;
    assign rdDataOut = st_q.rdData;
    assign memWrEn = st_q.wrEn;
    assign memWrBlock = st_q.wrBlock;
    assign memWrData = st_q.wrData;

    // ==========================================================
    // Register lock bank
    // ==========================================================
    // locked write filter
    rag_lock_bank #(
        .NCTL(NCTL)
    ) u_lock (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .wrEn(ctlWrEn),
        .wrSel(ctlWrSel),
        .wrData(ctlWrData),
        .lockSet(lockSet),
        .ctlRegs(ctlRegs),
        .lockBits(lockBits),
        .wrBlocked(ctlWrBlocked)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    a_read_never_filtered: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_READ && legal |=> respOut.grant)
        else $error("legal read was refused");
    a_low_block_open: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && legal && !filtered |=> respOut.valid && respOut.grant)
        else $error("low block access was refused");
    a_fetch_denied: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_FETCH && legal && filtered
        && !permPair[PERM_FETCH_BIT] |=> !respOut.grant && rdDataOut == '0)
        else $error("fetch passed without permission");
    a_write_denied: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_WRITE && legal && filtered
        && !permPair[PERM_WRITE_BIT] |=> !memWrEn)
        else $error("denied write reached memory");
    a_write_follows_grant: assert property (@(posedge ref_clk) disable iff (rst)
        memWrEn |-> respOut.grant && respOut.kind == ACC_WRITE)
        else $error("memory write without granted write");
    a_ext_block_filter: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_WRITE && legal
        && 32'(reqIn.block) == NBLK - 1 |=> respOut.grant == $past(permPair[PERM_WRITE_BIT]))
        else $error("external block write ignored its permission");
    a_cfg_runtime: assert property (@(posedge ref_clk) disable iff (rst)
        ce && cfgIn.wrEn && 32'(cfgIn.block) < NBLK
        |=> st_q.perm[$past(cfgIn.block)] == $past(cfgIn.perm))
        else $error("permission update lost");
    a_freeze_on_ce: assert property (@(posedge ref_clk) disable iff (rst)
        !ce |=> st_q == $past(st_q))
        else $error("state moved while ce low");

    // Request-side and reset checks: each restates a rule from the inputs
    a_read_data: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_READ && legal
        |=> rdDataOut == $past(memRdData))
        else $error("granted read lost its data");
    a_bad_init_refused: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.init == 2'h3
        |=> respOut.valid && !respOut.grant && rdDataOut == '0)
        else $error("request from unknown initiator passed");
    a_fetch_allowed: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_FETCH && legal && filtered
        && permPair[PERM_FETCH_BIT] |=> respOut.grant && rdDataOut == $past(memRdData))
        else $error("permitted fetch was refused");
    a_write_issued: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid && reqIn.kind == ACC_WRITE && legal
        && (32'(reqIn.block) < NLOW || permPair[PERM_WRITE_BIT])
        |=> memWrEn && memWrBlock == $past(reqIn.block) && memWrData == $past(reqIn.wrData))
        else $error("permitted write not issued");
    a_resp_echo: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reqIn.valid |=> respOut.valid && respOut.init == $past(reqIn.init)
        && respOut.block == $past(reqIn.block) && respOut.kind == $past(reqIn.kind))
        else $error("response does not match its request");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !reqIn.valid |=> !respOut.valid && !memWrEn && rdDataOut == '0)
        else $error("output active without a request");
    a_perm_reset: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> st_q.perm == {NBLK{PERM_RESET}})
        else $error("permissions not opened by reset");

    c_write_denied: cover property (@(posedge ref_clk) disable iff (rst)
        respOut.valid && !respOut.grant && respOut.kind == ACC_WRITE);
    c_fetch_granted: cover property (@(posedge ref_clk) disable iff (rst)
        respOut.grant && respOut.kind == ACC_FETCH && 32'(respOut.block) >= NLOW);
    c_cfg_then_deny: cover property (@(posedge ref_clk) disable iff (rst)
        cfgIn.wrEn ##1 respOut.valid && !respOut.grant);
    c_lock_blocks: cover property (@(posedge ref_clk) disable iff (rst) ctlWrBlocked);
endmodule : rag_guard
`default_nettype wire

// file: verilog/rag_lock_bank.sv
`timescale 1ns/1ps
`default_nettype none
module rag_lock_bank
    import rag_pkg::*;
#(
    parameter int NCTL = NUM_CTL
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Control register write port
    input wire logic wrEn,
    input wire logic [CTL_SEL_W-1:0] wrSel,
    input wire logic [CTL_W-1:0] wrData,
    // Lock set strobe, one bit per register
    input wire logic [NCTL-1:0] lockSet,
    // State
    output logic [NCTL-1:0][CTL_W-1:0] ctlRegs,
    output logic [NCTL-1:0] lockBits,
    output logic wrBlocked
);
    typedef struct packed {
        logic [NCTL-1:0][CTL_W-1:0] regs;
        logic [NCTL-1:0] lock;
        logic blocked;
    } rag_lock_state_t;

    rag_lock_state_t st_q;
    rag_lock_state_t st_d;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_d = st_q;
        st_d.blocked = 1'b0;
        // sticky lock bits
        // No input can clear a lock; only reset does
        st_d.lock = st_q.lock | lockSet;
        if (wrEn && st_q.lock[wrSel]) begin
            st_d.blocked = 1'b1;
        end else if (wrEn) begin
            st_d.regs[wrSel] = wrData;
        end
    end

    // Whole state frozen while ce is low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q.regs <= {NCTL{CTL_RESET}};
            st_q.lock <= '0;
            st_q.blocked <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign ctlRegs = st_q.regs;
    assign lockBits = st_q.lock;
    assign wrBlocked = st_q.blocked;

    // ==========================================================
    // Checks
    // ==========================================================
    a_lock_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 ((lockBits & $past(lockBits)) == $past(lockBits)))
        else $error("lock bit fell without reset");
    a_locked_reg_holds: assert property (@(posedge ref_clk) disable iff (rst)
        ce && wrEn && lockBits[wrSel] |=> ctlRegs == $past(ctlRegs) && wrBlocked)
        else $error("locked register changed on write");
    a_open_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
        ce && wrEn && !lockBits[wrSel] |=> ctlRegs[$past(wrSel)] == $past(wrData))
        else $error("unlocked write lost");
    a_lock_frozen: assert property (@(posedge ref_clk) disable iff (rst)
        !ce |=> ctlRegs == $past(ctlRegs) && lockBits == $past(lockBits))
        else $error("lock state moved while ce low");
    a_lock_reset: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> lockBits == '0 && ctlRegs == {NCTL{CTL_RESET}})
        else $error("reset left a register locked");
    c_locked_write: cover property (@(posedge ref_clk) disable iff (rst) wrBlocked);
endmodule : rag_lock_bank
`default_nettype wire

// file: verilog/rag_pkg.sv
`default_nettype none
package rag_pkg;
    // ==========================================================
    // Initiators and access kinds
    // ==========================================================
    localparam int NUM_INIT = 3;
    localparam logic [1:0] INIT_CPU = 2'h0;
    localparam logic [1:0] INIT_COPROC = 2'h1;
    localparam logic [1:0] INIT_DMA = 2'h2;

    typedef enum logic [1:0] {
        ACC_READ,
        ACC_FETCH,
        ACC_WRITE
    } rag_kind_t;

    // ==========================================================
    // Memory blocks and permission layout
    // ==========================================================
    localparam int BLK_W = 3;
    localparam int NUM_BLOCKS = 8;
    localparam int NUM_LOW_BLOCKS = 2;
    localparam int PERM_W = 2;
    localparam int PERM_FETCH_BIT = 0;
    localparam int PERM_WRITE_BIT = 1;
    localparam int PERM_ROW_W = NUM_INIT * PERM_W;
    localparam logic [PERM_ROW_W-1:0] PERM_RESET = 6'h3F;
    localparam int DATA_W = 32;

    // ==========================================================
    // Lockable control registers
    // ==========================================================
    localparam int NUM_CTL = 4;
    localparam int CTL_SEL_W = 2;
    localparam int CTL_W = 16;
    localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic valid;
        logic [1:0] init;
        logic [BLK_W-1:0] block;
        rag_kind_t kind;
        logic [DATA_W-1:0] wrData;
    } rag_req_t;

    typedef struct packed {
        logic valid;
        logic grant;
        logic [1:0] init;
        logic [BLK_W-1:0] block;
        rag_kind_t kind;
    } rag_resp_t;

    typedef struct packed {
        logic wrEn;
        logic [BLK_W-1:0] block;
        logic [PERM_ROW_W-1:0] perm;
    } rag_cfg_t;
endpackage : rag_pkg
`default_nettype wire
